// file: hdl/reset_seq_pkg.sv
/*
  Constants, register layout and event bundles for the reset status and release sequencer.
  Assumes a 40 MHz system clock; every delay is held in its own unit and turned into cycles here.
*/
package reset_seq_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] CAUSE_ADDR = 4'h0;
  localparam logic [3:0] OSC_CTRL_ADDR = 4'h4;

  // Field positions in reset_cause_status.
  localparam int B_TRAP = 15;
  localparam int B_ILLEGAL = 14;
  localparam int B_CFG_MISMATCH = 9;
  localparam int B_REG_KEEP = 8;
  localparam int B_PIN = 7;
  localparam int B_SOFT = 6;
  localparam int B_WDT_EN = 5;
  localparam int B_WDT_TO = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BROWNOUT = 1;
  localparam int B_POWER_ON = 0;
  localparam logic [15:0] CAUSE_RESET = 16'h0003;
  localparam logic [15:0] CAUSE_IMPL = 16'hC3FF;

  // current_oscillator_field position in oscillator_control.
  localparam int OSC_CUR_LSB = 12;
  localparam logic [2:0] OSC_RESET = 3'h0;

  // Timing, each figure in its own unit, then as cycles of mclk.
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_POR_NS = 10000;
  localparam int T_VREG_NS = 10000;
  localparam int T_POWER_UP_TIMER_MS = 64;
  localparam int T_RST_NS = 20000;
  localparam int T_LOCK_NS = 20000;
  localparam int T_FAIL_SAFE_CLOCK_MONITOR_NS = 100000;
  localparam int POR_CYC = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VREG_CYC = (T_VREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_TIMER_CYC = (T_POWER_UP_TIMER_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC = (T_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAIL_SAFE_CLOCK_MONITOR_CYC = (T_FAIL_SAFE_CLOCK_MONITOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 22;

  // Oscillator start-up timer: a 10-bit count of 1024 oscillator periods.
  localparam int OST_W = 10;
  localparam logic [OST_W-1:0] OST_LAST = 10'h3FF;

  // Reset requests from the core, one-cycle pulses on mclk.
  typedef struct packed {
    logic trap_conflict;
    logic illegal_op;
    logic config_mismatch;
    logic watchdog_timeout;
    logic reset_instr;
    logic brownout;
  } reset_src_t;

  // Power-saving instruction executed, one-cycle pulses on mclk.
  typedef struct packed {
    logic sleep;
    logic idle;
  } power_save_t;

endpackage

// file: hdl/reset_sequencer.sv
/*
  Reset status register, clock source choice at reset and master reset release timing.
  Assumes reset requests come as mclk pulses, sys_rst is the power-on reset, and the pin
  and oscillator sample inputs are asynchronous and slower than half the mclk rate.
*/
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

// Functional notes
// R1 - Trap conflict reset sets bit 15; only power-on clears it in hardware.
// R2 - Illegal opcode, address mode or uninitialised pointer reset sets bit 14.
// R3 - Bits 13 to 10 ignore writes and read zero.
// R4 - Configuration mismatch reset sets bit 9.
// R5 - Bit 8 keeps regulator active in sleep when one; resets to zero.
// R6 - Pin reset sets bit 7; only power-on clears it in hardware.
// R7 - Reset instruction sets bit 6; only power-on clears it in hardware.
// R8 - Bit 5 enables watchdog; unprogrammed fuse enables it regardless.
// R9 - Watchdog timeout sets bit 4; power-saving instruction or power-on clears it.
// R10 - Sleep power-saving instruction sets bit 3; power-on clears it.
// R11 - Idle power-saving instruction sets bit 2; power-on clears it.
// R12 - Brown-out and power-on set bit 1; reset value one, no hardware clear.
// R13 - Power-on sets bit 0; reset value one, no hardware clear.
// R14 - Software may set or clear any flag; setting never causes a reset.
// R15 - With switching, power-on/brown-out load config source; others keep current field.
// R16 - Without switching, every reset loads the configured clock source.
// R17 - Master reset waits power-on, start-up and internal delays by reset type.
// R18 - Power-on delay 10 us; start-up 10 us, or 64 ms regulator off.
// R19 - Internal reset time of 20 us follows every reset type.
// R20 - Crystal sources wait 1024 oscillator periods on a 10-bit counter.
// R21 - PLL waits 20 us lock; clock monitor starts 100 us after release; the code delays it only for crystal or PLL after a long reset.
// R22 - Clock waits run beside master reset; CPU waits for valid clock.
// R23 - Any active reset source asserts master reset.
// R24 - All delays are counters with parameterised terminal counts.
module reset_sequencer #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = reset_seq_pkg::POWER_UP_TIMER_CYC, // Power-up timer length in mclk cycles
  parameter logic [7:0] XTAL_SRC_MASK = 8'h0C, // Source codes that use a crystal
  parameter logic [7:0] PLL_SRC_MASK = 8'h0A, // Source codes that use the PLL
  parameter int unsigned POR_CYCLES = reset_seq_pkg::POR_CYC, // Power-on delay in mclk cycles
  parameter int unsigned VREG_CYCLES = reset_seq_pkg::VREG_CYC, // Regulator start-up in mclk cycles
  parameter int unsigned RST_CYCLES = reset_seq_pkg::RST_CYC, // Internal reset time in mclk cycles
  parameter int unsigned LOCK_CYCLES = reset_seq_pkg::LOCK_CYC, // PLL lock wait in mclk cycles
  parameter int unsigned FAIL_SAFE_CLOCK_MONITOR_CYCLES = reset_seq_pkg::FAIL_SAFE_CLOCK_MONITOR_CYC // Monitor start delay in mclk cycles
) (
  input wire logic mclk, // System clock, 40 MHz
  input wire logic sys_rst, // Power-on reset, asynchronous, active high
  input wire logic [3:0] avs_address, // Register byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // High while the request is not yet answered
  input wire reset_seq_pkg::reset_src_t reset_src, // Reset requests from the core
  input wire reset_seq_pkg::power_save_t power_saving_instruction, // Sleep or idle executed
  input wire logic master_clear_pin_n, // Master clear pin, low requests reset
  input wire logic osc_clk_in, // Oscillator output, sampled for start-up counting
  input wire logic clock_switch_en, // Clock switching enabled in configuration
  input wire logic [2:0] initial_oscillator_select, // Configured clock source
  input wire logic regulator_enable, // On-chip regulator enabled
  input wire logic watchdog_fuse_enable, // Watchdog fuse, one when unprogrammed
  output logic master_reset, // Master reset to core and peripherals
  output logic cpu_run, // Core may execute
  output logic clock_valid, // System clock released
  output logic clock_monitor_enable, // Clock monitor may watch the clock
  output logic [2:0] current_oscillator_field, // Clock source in use
  output logic watchdog_enabled, // Watchdog running
  output logic regulator_sleep_keep // Regulator stays active in sleep
);
  import reset_seq_pkg::*;

  // One machine times the master reset, a separate one qualifies the clock.
  typedef enum logic [1:0] {ST_POR, ST_STARTUP, ST_RST, ST_RUN} rst_state_t;
  typedef enum logic [1:0] {CK_START, CK_OST, CK_LOCK, CK_OK} clk_state_t;

  // Down-counters stop at zero, so each load is one less than the cycles it stands for.
  localparam logic [DLY_W-1:0] LD_POR = DLY_W'(POR_CYCLES - 1);
  localparam logic [DLY_W-1:0] LD_VREG = DLY_W'(VREG_CYCLES - 1);
  localparam logic [DLY_W-1:0] LD_POWER_UP_TIMER = DLY_W'(POWER_UP_TIMER_CYCLES - 1);
  localparam logic [DLY_W-1:0] LD_RST = DLY_W'(RST_CYCLES - 1);
  localparam logic [DLY_W-1:0] LD_LOCK = DLY_W'(LOCK_CYCLES - 1);
  localparam logic [DLY_W-1:0] LD_FAIL_SAFE_CLOCK_MONITOR = DLY_W'(FAIL_SAFE_CLOCK_MONITOR_CYCLES - 1);
  localparam logic [1:0] PIN_IDLE = 2'b10;

  rst_state_t st_q;
  clk_state_t ck_q;
  logic [DLY_W-1:0] dly_q;
  logic [DLY_W-1:0] lock_q;
  logic [DLY_W-1:0] fail_safe_clock_monitor_q;
  logic [OST_W-1:0] ost_q;
  logic [1:0] s1_q, s2_q, s3_q, pin_lvl_q;
  logic [1:0] pin_nxt;
  logic [15:0] cause_q, cause_d, hw_set, hw_clr, wr_mask;
  logic [2:0] osc_q;
  logic por_pending_q, long_q, wait_q, mreset_q, run_q, mon_q;
  logic [31:0] rdata_q;
  logic master_clear_pin_low, master_clear_pin_fall, osc_rise, minor_evt, bus_done, wr_cause;
  logic [DLY_W-1:0] startup_ld;
  logic sel_xtal, sel_pll, cur_slow;
  logic valid_q, wdt_on_q;

  // Pin and oscillator inputs pass three flops; a change counts once the last two agree.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      pin_lvl_q <= PIN_IDLE;
    end else begin
      s1_q <= {master_clear_pin_n, osc_clk_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_lvl_q <= pin_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_nxt[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_lvl_q[i];
    end
  end

  // Level and edge views of the synchronised pins. The stage resets to the idle levels,
  // so no false edge follows a power-on reset.
  assign master_clear_pin_low = ~pin_lvl_q[1];
  assign master_clear_pin_fall = pin_lvl_q[1] & ~pin_nxt[1];
  assign osc_rise = ~pin_lvl_q[0] & pin_nxt[0];
  assign minor_evt = reset_src.trap_conflict | reset_src.illegal_op | reset_src.config_mismatch
                   | reset_src.watchdog_timeout | reset_src.reset_instr | master_clear_pin_low;
  assign startup_ld = regulator_enable ? LD_VREG : LD_POWER_UP_TIMER; // R18
  assign sel_xtal = XTAL_SRC_MASK[initial_oscillator_select];
  assign sel_pll = PLL_SRC_MASK[initial_oscillator_select];
  assign cur_slow = long_q & (XTAL_SRC_MASK[osc_q] | PLL_SRC_MASK[osc_q]);

  // Master reset stages; a brown-out restarts at start-up, lesser resets at the internal stage.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_POR;
      dly_q <= LD_POR; // R17
      long_q <= 1'b1;
    end else if (reset_src.brownout) begin
      st_q <= ST_STARTUP; // R17
      dly_q <= startup_ld;
      long_q <= 1'b1;
    end else if (minor_evt && (st_q == ST_RUN || st_q == ST_RST)) begin
      st_q <= ST_RST; // R19
      dly_q <= LD_RST;
      if (st_q == ST_RUN) begin
        long_q <= 1'b0;
      end
    end else if (dly_q != '0) begin
      dly_q <= dly_q - 1'b1; // R24
    end else begin
      unique case (st_q)
        ST_POR: begin
          st_q <= ST_STARTUP;
          dly_q <= startup_ld;
        end
        ST_STARTUP: begin
          st_q <= ST_RST;
          dly_q <= LD_RST; // R19
        end
        ST_RST: st_q <= ST_RUN;
        ST_RUN: st_q <= ST_RUN;
      endcase
    end
  end

  // Any source forces master reset at once, before the stage machine catches up.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mreset_q <= 1'b1;
    end else begin
      mreset_q <= minor_evt | reset_src.brownout | (st_q != ST_RUN); // R23
    end
  end

  // The power-on source is caught one cycle after release, since the select is a plain port.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      por_pending_q <= 1'b1;
      osc_q <= OSC_RESET;
    end else begin
      por_pending_q <= 1'b0;
      if (por_pending_q || reset_src.brownout) begin
        osc_q <= initial_oscillator_select; // R15
      end else if (minor_evt && !clock_switch_en) begin
        osc_q <= initial_oscillator_select; // R16
      end
    end
  end

  // Oscillator and PLL waits run beside the master reset stages; only long resets restart them.
  // A lesser reset that changes the source without switching keeps the clock marked valid.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_q <= CK_START;
      ost_q <= '0;
      lock_q <= LD_LOCK;
    end else if (reset_src.brownout) begin
      ck_q <= CK_START; // R22
      ost_q <= '0;
      lock_q <= LD_LOCK;
    end else begin
      unique case (ck_q)
        CK_START: begin
          if (sel_xtal) begin
            ck_q <= CK_OST;
          end else if (sel_pll) begin
            ck_q <= CK_LOCK;
          end else begin
            ck_q <= CK_OK;
          end
        end
        CK_OST: begin
          if (osc_rise) begin
            ost_q <= ost_q + 1'b1; // R20
            if (ost_q == OST_LAST) begin
              ck_q <= sel_pll ? CK_LOCK : CK_OK;
            end
          end
        end
        CK_LOCK: begin
          if (lock_q != '0) begin
            lock_q <= lock_q - 1'b1; // R21
          end else begin
            ck_q <= CK_OK;
          end
        end
        CK_OK: ck_q <= CK_OK;
      endcase
    end
  end

  // Clock valid is registered; a brown-out drops it on the edge that restarts the waits,
  // so the core never starts on a clock that is about to be qualified again.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= (ck_q == CK_OK) & ~reset_src.brownout; // R22
    end
  end

  // The watchdog enable is registered too. The fuse is a static level,
  // so the extra cycle it takes here is harmless.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_on_q <= 1'b0;
    end else begin
      wdt_on_q <= cause_d[B_WDT_EN] | watchdog_fuse_enable; // R8
    end
  end

  // The core starts only when reset is released and the clock is valid.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= ~mreset_q & valid_q & ~minor_evt & ~reset_src.brownout; // R22
    end
  end

  // Clock monitor start: a delay after release for crystal or PLL sources after a long reset.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mon_q <= 1'b0;
      fail_safe_clock_monitor_q <= LD_FAIL_SAFE_CLOCK_MONITOR;
    end else if (mreset_q) begin
      mon_q <= 1'b0;
      fail_safe_clock_monitor_q <= cur_slow ? LD_FAIL_SAFE_CLOCK_MONITOR : '0; // R21
    end else if (fail_safe_clock_monitor_q != '0) begin
      fail_safe_clock_monitor_q <= fail_safe_clock_monitor_q - 1'b1;
    end else begin
      mon_q <= 1'b1;
    end
  end

  // One wait cycle per access: waitrequest drops for exactly the completing edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
    end
  end

  // Lanes 0 and 1 cover the 16-bit status register; the upper lanes have nothing behind them.
  assign bus_done = ~wait_q & (avs_read | avs_write);
  assign wr_cause = bus_done & avs_write & (avs_address == CAUSE_ADDR);
  assign wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Software may write any flag; the hardware events are merged after the write,
  // so an event is never lost to a write in the same cycle.
  always_comb begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[B_TRAP] = reset_src.trap_conflict; // R1
    hw_set[B_ILLEGAL] = reset_src.illegal_op; // R2
    hw_set[B_CFG_MISMATCH] = reset_src.config_mismatch; // R4
    hw_set[B_PIN] = master_clear_pin_fall; // R6
    hw_set[B_SOFT] = reset_src.reset_instr; // R7
    hw_set[B_WDT_TO] = reset_src.watchdog_timeout; // R9
    hw_clr[B_WDT_TO] = power_saving_instruction.sleep | power_saving_instruction.idle; // R9
    hw_set[B_SLEEP] = power_saving_instruction.sleep; // R10
    hw_set[B_IDLE] = power_saving_instruction.idle; // R11
    hw_set[B_BROWNOUT] = reset_src.brownout; // R12
    cause_d = cause_q;
    if (wr_cause) begin
      cause_d = (cause_q & ~wr_mask) | (avs_writedata[15:0] & wr_mask); // R14
    end
    // A hardware event in the same cycle as a clear keeps the flag set.
    cause_d = ((cause_d & ~hw_clr) | hw_set) & CAUSE_IMPL; // R3
  end

  // Power-on clears the sticky flags, and a power-saving instruction also clears bit 4; bits 1:0 come up set.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_q <= CAUSE_RESET; // R13
    end else begin
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
  // Read data is captured on the first request cycle, so it stands when waitrequest falls.
    end else if (avs_read && wait_q) begin
      unique case (avs_address)
        CAUSE_ADDR: rdata_q <= {16'h0000, cause_q};
        OSC_CTRL_ADDR: rdata_q <= 32'(osc_q) << OSC_CUR_LSB; // R15
        default: rdata_q <= '0;
      endcase
    end
  end

  // Every port below is a register or a plain copy of one.
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign master_reset = mreset_q;
  assign cpu_run = run_q;
  assign clock_valid = valid_q;
  assign clock_monitor_enable = mon_q;
  assign current_oscillator_field = osc_q;
  assign watchdog_enabled = wdt_on_q; // R8
  assign regulator_sleep_keep = cause_q[B_REG_KEEP]; // R5

endmodule // reset_sequencer

// file: bench/osc_model.sv
/* Far-side oscillator model: a slow square wave on osc_clk_in and a count of its rising edges.
   Assumes mclk is the system clock; half sets the cycles per level, at least 2. */
`timescale 1ns/1ps
module osc_model (
  input wire logic mclk, // system clock
  input wire logic run, // oscillator running
  input wire logic [1:0] half, // mclk cycles per level
  output logic osc_clk_in, // oscillator output
  output int rises // rising edges so far
);
  logic [1:0] ph_q;
  initial begin
    osc_clk_in = 1'b0;
    rises = 0;
    ph_q = 2'h0;
  end
  // The wave stands still while the oscillator is stopped.
  always @(posedge mclk) begin
    if (run && ph_q + 2'h1 >= half) begin
      ph_q <= 2'h0;
      osc_clk_in <= !osc_clk_in;
      if (!osc_clk_in) rises <= rises + 1;
    end else if (run) begin
      ph_q <= ph_q + 2'h1;
    end
  end
endmodule // osc_model

// file: bench/reset_seq_checker.sv
/* Port-level assertions for the reset sequencer.
   Assumes one clock, mclk, with sys_rst as the power-on reset. */
`timescale 1ns/1ps
module reset_seq_checker (
  input wire logic mclk, // clock
  input wire logic sys_rst, // power-on reset
  input wire logic [3:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // wait
  input wire reset_seq_pkg::reset_src_t reset_src, // reset requests
  input wire logic clock_switch_en, // switching on
  input wire logic [2:0] initial_oscillator_select, // configured source
  input wire logic watchdog_fuse_enable, // fuse
  input wire logic master_reset, // master reset
  input wire logic cpu_run, // core runs
  input wire logic clock_valid, // clock released
  input wire logic [2:0] current_oscillator_field, // source in use
  input wire logic watchdog_enabled, // watchdog on
  input wire logic regulator_sleep_keep // regulator kept
);
  import reset_seq_pkg::*;
  int hi_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Counting held cycles catches a release shorter than the internal reset time.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hi_q <= 0;
    else hi_q <= master_reset ? hi_q + 1 : 0;
  end
  sequence s_done; (avs_read || avs_write) && !avs_waitrequest; endsequence
  sequence s_wr; s_done ##0 avs_write && avs_address == CAUSE_ADDR; endsequence
  property p_wait_one; s_done |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low twice");
  property p_unimpl; s_done ##0 avs_read && avs_address == CAUSE_ADDR |-> (avs_readdata & 32'hFFFF3C00) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bits set");
  property p_keep; s_wr ##0 avs_byteenable[1] |=> regulator_sleep_keep == $past(avs_writedata[B_REG_KEEP]); endproperty
  a_keep: assert property (p_keep) else $error("regulator bit");
  property p_fuse; watchdog_fuse_enable |=> watchdog_enabled; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse ignored");
  property p_src; (|reset_src) |=> master_reset; endproperty
  a_src: assert property (p_src) else $error("no master reset");
  property p_len; $fell(master_reset) |-> hi_q >= RST_CYC; endproperty
  a_len: assert property (p_len) else $error("release too early");
  property p_osc_keep; reset_src.reset_instr && clock_switch_en |=> $stable(current_oscillator_field) [*3]; endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("source changed");
  property p_reload; reset_src.reset_instr && !clock_switch_en |-> ##[1:3]
    current_oscillator_field == initial_oscillator_select; endproperty
  a_reload: assert property (p_reload) else $error("source not loaded");
  property p_run; master_reset || !clock_valid |=> !cpu_run; endproperty
  a_run: assert property (p_run) else $error("core ran early");
endmodule // reset_seq_checker

bind reset_sequencer reset_seq_checker u_chk (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .reset_src, .clock_switch_en, .initial_oscillator_select,
  .watchdog_fuse_enable, .master_reset, .cpu_run, .clock_valid, .current_oscillator_field, .watchdog_enabled,
  .regulator_sleep_keep);

// file: bench/reset_sequencer_tb.sv
/* Self-checking bench for the reset sequencer with an oscillator model.
   Assumes the power-up timer is shortened to PW cycles. */
`timescale 1ns/1ps
module reset_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int PW = 50;
  localparam logic [15:0] FL [5] = '{16'h8000, 16'h4000, 16'h0200, 16'h0010, 16'h0040};
  logic mclk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, master_clear_pin_n = 1'b1;
  logic clock_switch_en = 1'b1, regulator_enable = 1'b0, watchdog_fuse_enable = 1'b0, run = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h3;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, master_reset, cpu_run, clock_valid, clock_monitor_enable, osc_clk_in;
  logic watchdog_enabled, regulator_sleep_keep;
  logic [2:0] initial_oscillator_select = 3'h2, current_oscillator_field;
  reset_src_t reset_src = '0;
  power_save_t power_saving_instruction = '0;
  int miscompares = 0, checked = 0, cyc = 0, rises, r0;
  osc_model OSC (.mclk, .run, .half(2'h2), .osc_clk_in, .rises);
  reset_sequencer #(.POWER_UP_TIMER_CYCLES(PW)) DUT (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .reset_src, .power_saving_instruction, .master_clear_pin_n,
    .osc_clk_in, .clock_switch_en, .initial_oscillator_select, .regulator_enable, .watchdog_fuse_enable,
    .master_reset, .cpu_run, .clock_valid, .clock_monitor_enable, .current_oscillator_field, .watchdog_enabled,
    .regulator_sleep_keep);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Every task starts just after a rising edge and ends on one.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus wait states", 32'(n), 32'h2);
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, 4'h3);
    chk(nm, q, e);
  endtask
  task automatic pulse(input reset_src_t s, input power_save_t p);
    reset_src <= s;
    power_saving_instruction <= p;
    @(posedge mclk);
    reset_src <= '0;
    power_saving_instruction <= '0;
    @(posedge mclk);
  endtask
  task automatic rel(input string nm, input int lo, input int hi);
    int n;
    n = 0;
    while (master_reset !== 1'b1 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (master_reset === 1'b1 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    chk(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic t_por;
    int n, rv;
    rd(CAUSE_ADDR, 32'h3, "cause after power-on");
    rd(OSC_CTRL_ADDR, 32'h2000, "source after power-on");
    rel("power-on hold", POR_CYC + PW + RST_CYC - 14, POR_CYC + PW + RST_CYC + 4);
    chk("core held", cpu_run, 32'h0);
    n = 0;
    rv = -1;
    while (clock_monitor_enable !== 1'b1 && n < 8000) begin
      @(posedge mclk);
      n++;
      if (rv < 0 && clock_valid === 1'b1) rv = rises - r0;
    end
    chk("oscillator periods", 32'(rv >= 1023 && rv <= 1027), 32'h1);
    chk("monitor delay", 32'(n >= FAIL_SAFE_CLOCK_MONITOR_CYC - 1 && n <= FAIL_SAFE_CLOCK_MONITOR_CYC + 3), 32'h1);
    chk("core runs", cpu_run, 32'h1);
    $display("power-on test done");
  endtask
  task automatic t_soft;
    bus(1'b1, CAUSE_ADDR, 32'hFFFF, 4'h3);
    rd(CAUSE_ADDR, 32'(CAUSE_IMPL), "all flags set");
    chk("no reset from flags", master_reset, 32'h0);
    chk("regulator kept", regulator_sleep_keep, 32'h1);
    chk("watchdog by software", watchdog_enabled, 32'h1);
    bus(1'b1, CAUSE_ADDR, 32'h0, 4'h1);
    rd(CAUSE_ADDR, 32'hC300, "low lane cleared");
    bus(1'b1, 4'h8, 32'hFFFF, 4'h3);
    rd(4'h8, 32'h0, "unmapped read");
    bus(1'b1, CAUSE_ADDR, 32'h0, 4'h3);
    chk("watchdog off", watchdog_enabled, 32'h0);
    watchdog_fuse_enable <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("watchdog by fuse", watchdog_enabled, 32'h1);
    watchdog_fuse_enable <= 1'b0;
    @(posedge mclk);
    $display("software flag test done");
  endtask
  task automatic t_flags;
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, CAUSE_ADDR, 32'h0, 4'h3);
      pulse(reset_src_t'(6'h20 >> k), '0);
      rel("minor hold", RST_CYC - 3, RST_CYC + 4);
      rd(CAUSE_ADDR, 32'(FL[k]), "cause flag");
    end
    bus(1'b1, CAUSE_ADDR, 32'h0, 4'h3);
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    master_clear_pin_n <= 1'b1;
    rel("pin hold", RST_CYC - 3, RST_CYC + 8);
    rd(CAUSE_ADDR, 32'h80, "pin flag");
    $display("reset flag test done");
  endtask
  task automatic t_power_saving_instruction;
    bus(1'b1, CAUSE_ADDR, 32'h10, 4'h3);
    pulse('0, power_save_t'(2'h2));
    rd(CAUSE_ADDR, 32'h8, "sleep flag");
    pulse('0, power_save_t'(2'h1));
    rd(CAUSE_ADDR, 32'hC, "idle flag");
    $display("power-saving test done");
  endtask
  task automatic t_bor;
    bus(1'b1, CAUSE_ADDR, 32'h0, 4'h3);
    initial_oscillator_select <= 3'h1;
    pulse(reset_src_t'(6'h01), '0);
    rel("brown-out hold", PW + RST_CYC - 3, PW + RST_CYC + 4);
    rd(CAUSE_ADDR, 32'h2, "brown-out flag");
    rd(OSC_CTRL_ADDR, 32'h1000, "brown-out source");
    initial_oscillator_select <= 3'h4;
    pulse(reset_src_t'(6'h02), '0);
    rel("minor hold", RST_CYC - 3, RST_CYC + 4);
    rd(OSC_CTRL_ADDR, 32'h1000, "source kept");
    clock_switch_en <= 1'b0;
    pulse(reset_src_t'(6'h02), '0);
    rel("minor hold", RST_CYC - 3, RST_CYC + 4);
    rd(OSC_CTRL_ADDR, 32'h4000, "source reloaded");
    $display("brown-out test done");
  endtask
  task automatic t_repor;
    bus(1'b1, CAUSE_ADDR, 32'hFFFF, 4'h3);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(CAUSE_ADDR, 32'h3, "cause after second power-on");
    rd(OSC_CTRL_ADDR, 32'h4000, "source after second power-on");
    rel("second power-on hold", POR_CYC + PW + RST_CYC - 14, POR_CYC + PW + RST_CYC + 4);
    $display("second power-on test done");
  endtask
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    r0 = rises;
    t_por;
    t_soft;
    t_flags;
    t_power_saving_instruction;
    t_bor;
    t_repor;
    end_of_test;
  end
endmodule // reset_sequencer_tb
